// ---- shared/vrsc_defines.svh ----
// Constants for the rail startup and configuration sequencer
// What this block does
// [RULE1] Ready within 2.5 ms of enable
// [RULE2] Filter enable fall, recognise within 1 us
// [RULE3] Drop ready within 500 ns of disable
// [RULE4] Boot ramp starts no later than ready deadline
// [RULE5] After supply good, capture straps, PWM mid
// [RULE6] Drive gate driver enable high when enabled
// [RULE7] Counter ramps DAC zero to boot voltage
// [RULE8] Rail PWM leaves mid on first pulse
// [RULE9] Disable returns all PWM to mid
// [RULE10] Ready at ramp end, or bus-ready if zero
// [RULE11] Phase count from sense inputs at supply
// [RULE12] System-power input tied high disables address 0Dh
// [RULE13] Measure each strap pin, decode setting
// [RULE14] Sixteen frequencies, lowest code 180 kHz
// [RULE15] Six boot targets in ascending order
// [RULE16] Slew strap selects 10 or 30 mV/us
// [RULE17] Eight address codes, four pairs twice
// [RULE18] Load max current at enable, 255 at 2.5 V
// [RULE19] Operating mode chosen by power state
// [RULE20] Single-phase full power uses ripple control
// [RULE21] Low power states pick CCM/DCM by load
// [RULE22] Report system power at address 0Dh
// [RULE23] Strap settings held until next supply cycle
`ifndef VRSC_DEFINES_SVH
`define VRSC_DEFINES_SVH
`define VRSC_CLK_MHZ 200
`define VRSC_READY_MAX_US 2500
`define VRSC_FILTER_MAX_NS 1000
`define VRSC_UNREADY_MAX_NS 500
`define VRSC_FILTER_CYC ((`VRSC_FILTER_MAX_NS * `VRSC_CLK_MHZ) / 1000)
`define VRSC_UNREADY_CYC ((`VRSC_UNREADY_MAX_NS * `VRSC_CLK_MHZ) / 1000)
`define VRSC_READY_CYC (`VRSC_READY_MAX_US * `VRSC_CLK_MHZ)
`define VRSC_SLEW_SLOW_MV_US 10
`define VRSC_SLEW_FAST_MV_US 30
`define VRSC_DAC_MV_LSB 5
`define VRSC_BOOT0_MV 12'd0
`define VRSC_BOOT1_MV 12'd800
`define VRSC_BOOT2_MV 12'd1050
`define VRSC_BOOT3_MV 12'd1200
`define VRSC_BOOT4_MV 12'd1400
`define VRSC_BOOT5_MV 12'd1500
`define VRSC_ADDR_CORE 4'h0
`define VRSC_ADDR_GFX 4'h1
`define VRSC_ADDR_SA 4'h2
`define VRSC_ADDR_UNSLICED_GRAPHICS_ADDRESS 4'h3
`define VRSC_ADDR_SYSTEM_POWER_INPUT 8'h0d
`define VRSC_REG_MAX_CURRENT 8'h21
`define VRSC_STRAP_FULL_MV 2500
`define VRSC_STRAP_FULL_CODE 255
`define VRSC_FREQ_BASE_KHZ 11'd180
`endif

// ---- shared/vrsc_pkg.sv ----
// Types for the rail startup and configuration sequencer
package vrsc_pkg;
  typedef enum logic [2:0] {
    VRSC_OFF = 3'b000,
    VRSC_ARMED = 3'b001,
    VRSC_RAMP = 3'b011,
    VRSC_RUN = 3'b010,
    VRSC_DOWN = 3'b110
  } vrsc_state_t;
  typedef enum logic [1:0] {
    VRSC_PWM_LOW = 2'b00,
    VRSC_PWM_MID = 2'b01,
    VRSC_PWM_HIGH = 2'b10
  } vrsc_pwm_t;
  typedef enum logic [2:0] {
    VRSC_MODE_DUAL_EDGE = 3'd0,
    VRSC_MODE_CCM_RIPPLE = 3'd1,
    VRSC_MODE_DCM_RIPPLE = 3'd2,
    VRSC_MODE_CCM_LOWPWR = 3'd3,
    VRSC_MODE_STANDBY = 3'd4
  } vrsc_mode_t;
endpackage

// ---- rtl/vrsc_sequencer.sv ----
// Startup, shutdown and strap configuration sequencer for a dual-rail controller
`timescale 1ns/1ps
`include "vrsc_defines.svh"
module vrsc_sequencer
  import vrsc_pkg::*;
#(
  parameter int NPH = 6,
  parameter int READY_CYC = `VRSC_READY_CYC,
  parameter int BUS_READY_CYC = 200
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic supply_good,
  input wire logic rail_enable_in,
  input wire logic [3:0] freq_strap_code,
  input wire logic [2:0] boot_strap_code,
  input wire logic slew_strap_code,
  input wire logic [2:0] addr_strap_code,
  input wire logic [7:0] max_current_strap,
  input wire logic [NPH-1:0] phase_current_sense_input,
  input wire logic system_power_input,
  input wire logic [7:0] system_power_sample,
  input wire logic [2:0] power_state,
  input wire logic light_load_in,
  input wire logic [1:0] rail_pulse_in,
  input wire logic bus_rd,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_reg,
  output logic rails_ready_out,
  output logic gate_driver_enable_out,
  output vrsc_pwm_t [1:0] rail_pwm_out,
  output logic [11:0] dac_mv_out,
  output logic [10:0] switching_freq_khz,
  output logic [1:0] slew_select_out,
  output logic [3:0] main_rail_address,
  output logic [3:0] second_rail_address,
  output logic [NPH-1:0] active_phase_mask,
  output logic system_power_enabled,
  output logic [7:0] max_current_setting,
  output vrsc_mode_t rail_mode_out,
  output logic bus_ack,
  output logic [7:0] bus_rdata
);
  localparam int FILT_CYC = `VRSC_FILTER_CYC;
  localparam int UNR_CYC = `VRSC_UNREADY_CYC;
  // Cycles per DAC LSB at each slew rate
  localparam int STEP_SLOW = (`VRSC_DAC_MV_LSB * `VRSC_CLK_MHZ) / `VRSC_SLEW_SLOW_MV_US;
  localparam int STEP_FAST = (`VRSC_DAC_MV_LSB * `VRSC_CLK_MHZ) / `VRSC_SLEW_FAST_MV_US;

  vrsc_state_t state_reg, state_next;
  logic strap_done_reg;
  logic [11:0] boot_mv_reg;
  logic slew_fast_reg;
  logic [7:0] filt_cnt_reg;
  logic en_filt_reg;
  logic [23:0] ready_cnt_reg;
  logic [7:0] step_cnt_reg;
  logic [7:0] down_cnt_reg;
  logic [1:0] pulse_seen_reg;

  // Glitch filter: a rise passes at once when armed, a fall must persist the filter time
  wire en_fall_pending = en_filt_reg && !rail_enable_in;
  wire filt_expire = en_fall_pending && (filt_cnt_reg == 8'(FILT_CYC - 1));
  wire ramp_done = (dac_mv_out >= boot_mv_reg);
  wire [7:0] step_len = slew_fast_reg ? 8'(STEP_FAST) : 8'(STEP_SLOW);
  wire step_now = (step_cnt_reg == step_len - 8'd1);
  wire boot_zero = (boot_mv_reg == `VRSC_BOOT0_MV);
  wire bus_ready_hit = (ready_cnt_reg >= 24'(BUS_READY_CYC));
  wire ready_cond = boot_zero ? bus_ready_hit : ramp_done;
  wire down_done = (down_cnt_reg == 8'(UNR_CYC - 1));
  wire system_power_input_hit = (bus_addr == `VRSC_ADDR_SYSTEM_POWER_INPUT);
  wire main_hit = (bus_addr[3:0] == main_rail_address) && (bus_addr[7:4] == 4'h0);
  wire second_hit = (bus_addr[3:0] == second_rail_address) && (bus_addr[7:4] == 4'h0);
  wire reg_icc = (bus_reg == `VRSC_REG_MAX_CURRENT);
  logic [11:0] boot_dec;
  logic [3:0] addr_a, addr_b;
  logic ack_next;
  logic [7:0] rdata_next;
  vrsc_mode_t mode_next;

  // Boot voltage table, ascending resistor order
  always_comb
  begin
    case (boot_strap_code) // RULE15
      3'd0: boot_dec = `VRSC_BOOT0_MV;
      3'd1: boot_dec = `VRSC_BOOT1_MV;
      3'd2: boot_dec = `VRSC_BOOT2_MV;
      3'd3: boot_dec = `VRSC_BOOT3_MV;
      3'd4: boot_dec = `VRSC_BOOT4_MV;
      default: boot_dec = `VRSC_BOOT5_MV;
    endcase
  end

  // Address pairs repeat every four codes
  always_comb
  begin
    case (addr_strap_code[1:0]) // RULE17
      2'd0:
      begin
        addr_a = `VRSC_ADDR_CORE;
        addr_b = `VRSC_ADDR_GFX;
      end
      2'd1:
      begin
        addr_a = `VRSC_ADDR_GFX;
        addr_b = `VRSC_ADDR_CORE;
      end
      2'd2:
      begin
        addr_a = `VRSC_ADDR_CORE;
        addr_b = `VRSC_ADDR_SA;
      end
      default:
      begin
        addr_a = `VRSC_ADDR_GFX;
        addr_b = `VRSC_ADDR_UNSLICED_GRAPHICS_ADDRESS;
      end
    endcase
  end

  always_comb
  begin
    case (power_state) // RULE19
      3'd0: mode_next = (active_phase_mask[NPH-1:1] == '0) ? VRSC_MODE_CCM_RIPPLE : VRSC_MODE_DUAL_EDGE; // RULE20
      3'd1: mode_next = VRSC_MODE_CCM_RIPPLE;
      3'd2, 3'd3: mode_next = light_load_in ? VRSC_MODE_DCM_RIPPLE : VRSC_MODE_CCM_LOWPWR; // RULE21
      default: mode_next = VRSC_MODE_STANDBY;
    endcase
  end

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      VRSC_OFF:
        if (strap_done_reg)
          state_next = VRSC_ARMED;
      VRSC_ARMED:
        if (en_filt_reg)
          state_next = VRSC_RAMP;
      VRSC_RAMP:
        if (!en_filt_reg)
          state_next = VRSC_DOWN;
        else if (ready_cond)
          state_next = VRSC_RUN; // RULE10
      VRSC_RUN:
        if (!en_filt_reg)
          state_next = VRSC_DOWN;
      default:
        if (down_done)
          state_next = VRSC_ARMED;
    endcase
  end

  // Bus: system-power address only answers when the function is present
  always_comb
  begin
    ack_next = 1'b0;
    rdata_next = 8'h00;
    if (!bus_rd || !rails_ready_out)
      ack_next = 1'b0;
    else if (system_power_input_hit)
    begin
      ack_next = system_power_enabled; // RULE12
      rdata_next = system_power_enabled ? system_power_sample : 8'h00; // RULE22
    end
    else if ((main_hit || second_hit) && reg_icc)
    begin
      ack_next = 1'b1;
      rdata_next = max_current_setting; // RULE18
    end
    else if (main_hit || second_hit)
      ack_next = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst || !supply_good)
    begin
      state_reg <= VRSC_OFF;
      strap_done_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      strap_done_reg <= 1'b1;
    end
  end

  // Straps captured once per supply cycle
  always_ff @(posedge core_clk)
  begin
    if (rst || !supply_good)
    begin
      boot_mv_reg <= `VRSC_BOOT0_MV;
      slew_fast_reg <= 1'b0;
      switching_freq_khz <= `VRSC_FREQ_BASE_KHZ;
      slew_select_out <= 2'd0;
      main_rail_address <= `VRSC_ADDR_CORE;
      second_rail_address <= `VRSC_ADDR_GFX;
      active_phase_mask <= '0;
      system_power_enabled <= 1'b0;
    end
    else if (!strap_done_reg) // RULE23
    begin
      boot_mv_reg <= boot_dec; // RULE13
      slew_fast_reg <= slew_strap_code; // RULE16
      slew_select_out <= slew_strap_code ? 2'd1 : 2'd0;
      switching_freq_khz <= `VRSC_FREQ_BASE_KHZ + 11'(freq_strap_code) * 11'd45
        + ((freq_strap_code > 4'd8) ? 11'(freq_strap_code - 4'd8) * 11'd45 : 11'd0); // RULE14
      main_rail_address <= addr_a;
      second_rail_address <= addr_b;
      active_phase_mask <= ~phase_current_sense_input; // RULE11
      system_power_enabled <= !system_power_input; // RULE12
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      en_filt_reg <= 1'b0;
      filt_cnt_reg <= 8'd0;
    end
    else if (rail_enable_in)
    begin
      en_filt_reg <= en_filt_reg | (state_reg == VRSC_ARMED);
      filt_cnt_reg <= 8'd0;
    end
    else if (filt_expire)
    begin
      en_filt_reg <= 1'b0; // RULE2
      filt_cnt_reg <= 8'd0;
    end
    else if (en_fall_pending)
      filt_cnt_reg <= filt_cnt_reg + 8'd1;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst || state_reg != VRSC_RAMP)
    begin
      ready_cnt_reg <= 24'd0;
      step_cnt_reg <= 8'd0;
    end
    else
    begin
      ready_cnt_reg <= ready_cnt_reg + 24'd1; // RULE1
      step_cnt_reg <= step_now ? 8'd0 : step_cnt_reg + 8'd1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      dac_mv_out <= 12'd0;
    else if (state_reg == VRSC_RAMP && !ramp_done && step_now)
      dac_mv_out <= dac_mv_out + 12'(`VRSC_DAC_MV_LSB); // RULE7 RULE4
    else if (state_reg == VRSC_OFF || state_reg == VRSC_ARMED)
      dac_mv_out <= 12'd0;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst || state_reg != VRSC_DOWN)
      down_cnt_reg <= 8'd0;
    else
      down_cnt_reg <= down_cnt_reg + 8'd1;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rails_ready_out <= 1'b0;
      gate_driver_enable_out <= 1'b0;
      pulse_seen_reg <= 2'b00;
      max_current_setting <= 8'h00;
      rail_mode_out <= VRSC_MODE_STANDBY;
      bus_ack <= 1'b0;
      bus_rdata <= 8'h00;
    end
    else
    begin
      rails_ready_out <= (state_next == VRSC_RUN); // RULE3 RULE10
      gate_driver_enable_out <= (state_next == VRSC_RAMP) || (state_next == VRSC_RUN); // RULE6
      if (state_reg == VRSC_ARMED && en_filt_reg)
        max_current_setting <= 8'((16'(max_current_strap) * 16'(`VRSC_STRAP_FULL_CODE)) / 16'd255); // RULE18
      if (state_reg == VRSC_RAMP || state_reg == VRSC_RUN)
        pulse_seen_reg <= pulse_seen_reg | rail_pulse_in;
      else
        pulse_seen_reg <= 2'b00; // RULE9
      rail_mode_out <= mode_next;
      bus_ack <= ack_next;
      bus_rdata <= rdata_next;
    end
  end

  // PWM stays mid until each rail's first pulse
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_rail
      always_ff @(posedge core_clk)
      begin
        if (rst || !strap_done_reg || !gate_driver_enable_out)
          rail_pwm_out[gi] <= VRSC_PWM_MID; // RULE5 RULE9
        else if (pulse_seen_reg[gi] || rail_pulse_in[gi])
          rail_pwm_out[gi] <= VRSC_PWM_HIGH; // RULE8
        else
          rail_pwm_out[gi] <= VRSC_PWM_MID;
      end
    end
  endgenerate
endmodule

// ---- tb/vrsc_sequencer_chk.sv ----
// Port assertions for the rail sequencer
`timescale 1ns/1ps
module vrsc_sequencer_chk
  import vrsc_pkg::*;
#(
  parameter int NPH = 6
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic supply_good,
  input wire logic rail_enable_in,
  input wire logic [2:0] power_state,
  input wire logic light_load_in,
  input wire logic [1:0] rail_pulse_in,
  input wire logic bus_rd,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_reg,
  input wire logic rails_ready_out,
  input wire logic gate_driver_enable_out,
  input wire vrsc_pwm_t [1:0] rail_pwm_out,
  input wire logic [11:0] dac_mv_out,
  input wire logic [10:0] switching_freq_khz,
  input wire logic [3:0] main_rail_address,
  input wire logic [NPH-1:0] active_phase_mask,
  input wire logic system_power_enabled,
  input wire logic [7:0] max_current_setting,
  input wire vrsc_mode_t rail_mode_out,
  input wire logic bus_ack,
  input wire logic [7:0] bus_rdata
);
  logic [8:0] low_cnt;
  vrsc_mode_t exp_mode;
  assign exp_mode = power_state == 3'd4 ? VRSC_MODE_STANDBY :
    power_state[1] ? (light_load_in ? VRSC_MODE_DCM_RIPPLE : VRSC_MODE_CCM_LOWPWR) :
    (power_state[0] || $countones(active_phase_mask) < 2) ? VRSC_MODE_CCM_RIPPLE : VRSC_MODE_DUAL_EDGE;
  // Saturates so a long disable never wraps back into the window
  always_ff @(posedge core_clk)
  begin
    if (rst || rail_enable_in)
      low_cnt <= 9'h0;
    else if (low_cnt != 9'h1ff)
      low_cnt <= low_cnt + 9'h1;
  end
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_unready_bound: assert property (low_cnt == 9'd300 |-> !rails_ready_out && !gate_driver_enable_out)
    else $error("Ready still high after disable window");
  a_system_power_input_refused: assert property (bus_rd && bus_addr == 8'h0d && !system_power_enabled |=> !bus_ack)
    else $error("Disabled system power address answered");
  a_max_current_read: assert property (bus_rd && rails_ready_out && bus_reg == 8'h21
    && bus_addr == {4'h0, main_rail_address} |=> bus_ack && bus_rdata == $past(max_current_setting))
    else $error("Max current read wrong");
  a_pwm_mid_idle: assert property (!gate_driver_enable_out && !$past(gate_driver_enable_out)
    |-> rail_pwm_out == {VRSC_PWM_MID, VRSC_PWM_MID})
    else $error("PWM not mid while drivers off");
  a_pwm_high_cause: assert property (rail_pwm_out[0] == VRSC_PWM_HIGH && $past(rail_pwm_out[0]) == VRSC_PWM_MID
    |-> $past(rail_pulse_in[0]) || $past(rail_pulse_in[0], 2))
    else $error("PWM left mid without a pulse");
  a_dac_step: assert property (gate_driver_enable_out && $past(gate_driver_enable_out)
    && dac_mv_out != $past(dac_mv_out) |-> dac_mv_out == $past(dac_mv_out) + 12'd5)
    else $error("DAC step is not one count up");
  a_mode_map: assert property (gate_driver_enable_out && $past(gate_driver_enable_out)
    && $stable(power_state) && $stable(light_load_in) |-> rail_mode_out == exp_mode)
    else $error("Mode does not match power state");
  a_straps_held: assert property (!$past(rst) && !$past(rst, 2) && supply_good && $past(supply_good)
    && $past(supply_good, 2) && $past(supply_good, 3) |-> $stable(switching_freq_khz) && $stable(main_rail_address))
    else $error("Strap setting changed while supply good");
endmodule

// ---- tb/vrsc_host_model.sv ----
// Processor side: platform enable, modulator pulses and bus reads
`timescale 1ns/1ps
module vrsc_host_model
(
  input wire logic core_clk,
  output logic rail_enable_in,
  output logic [1:0] rail_pulse_in,
  output logic bus_rd,
  output logic [7:0] bus_addr,
  output logic [7:0] bus_reg,
  input wire logic bus_ack,
  input wire logic [7:0] bus_rdata
);
  initial
  begin
    rail_enable_in = 1'b0;
    rail_pulse_in = 2'b00;
    bus_rd = 1'b0;
    bus_addr = 8'h00;
    bus_reg = 8'h00;
  end
  task automatic read(input logic [7:0] a, input logic [7:0] r, output logic ack, output logic [7:0] d);
    @(negedge core_clk);
    bus_rd = 1'b1;
    bus_addr = a;
    bus_reg = r;
    // Answer stands only in the cycle after the request, so take it before releasing
    @(negedge core_clk);
    ack = bus_ack;
    d = bus_rdata;
    bus_rd = 1'b0;
    // Released lines flip so a stale address can never look valid
    bus_addr = ~a;
    bus_reg = ~r;
  endtask
  task automatic set_enable(input logic v);
    @(negedge core_clk);
    rail_enable_in = v;
  endtask
  task automatic pulse(input logic [1:0] p);
    @(negedge core_clk);
    rail_pulse_in = p;
    @(negedge core_clk);
    rail_pulse_in = 2'b00;
  endtask
endmodule

// ---- tb/vrsc_sequencer_bench.sv ----
// Self-checking bench for the rail sequencer
`timescale 1ns/1ps
module vrsc_sequencer_bench;
  import vrsc_pkg::*;
  logic core_clk, rst, supply_good, slew_strap_code, system_power_input, light_load_in;
  logic [3:0] freq_strap_code;
  logic [2:0] boot_strap_code, addr_strap_code, power_state;
  logic [7:0] max_current_strap, system_power_sample, bus_addr, bus_reg, bus_rdata, max_current_setting;
  logic [5:0] phase_current_sense_input, active_phase_mask;
  logic [1:0] rail_pulse_in, slew_select_out;
  logic rail_enable_in, bus_rd, bus_ack, rails_ready_out, gate_driver_enable_out, system_power_enabled;
  vrsc_pwm_t [1:0] rail_pwm_out;
  vrsc_mode_t rail_mode_out;
  logic [11:0] dac_mv_out;
  logic [10:0] switching_freq_khz;
  logic [3:0] main_rail_address, second_rail_address;
  int mismatches = 0;
  int checks_done = 0;
  int tgt [6] = '{0, 800, 1050, 1200, 1400, 1500};
  int sec [4] = '{1, 0, 2, 3};
  vrsc_sequencer #(.BUS_READY_CYC(10)) i_dut (.core_clk, .rst, .supply_good, .rail_enable_in, .freq_strap_code,
    .boot_strap_code, .slew_strap_code, .addr_strap_code, .max_current_strap, .phase_current_sense_input,
    .system_power_input, .system_power_sample, .power_state, .light_load_in, .rail_pulse_in, .bus_rd, .bus_addr,
    .bus_reg, .rails_ready_out, .gate_driver_enable_out, .rail_pwm_out, .dac_mv_out, .switching_freq_khz,
    .slew_select_out, .main_rail_address, .second_rail_address, .active_phase_mask, .system_power_enabled,
    .max_current_setting, .rail_mode_out, .bus_ack, .bus_rdata);
  vrsc_host_model i_host (.core_clk, .rail_enable_in, .rail_pulse_in, .bus_rd, .bus_addr, .bus_reg, .bus_ack,
    .bus_rdata);
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic summarize();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_ready(input logic want, input int lim);
    int i;
    for (i = 0; i < lim && rails_ready_out !== want; i++)
      @(negedge core_clk);
    if (i == lim)
    begin
      mismatches++;
      summarize();
    end
  endtask
  task automatic power_up(input logic [3:0] f, input logic [2:0] b, input logic s, input logic [2:0] a);
    @(negedge core_clk);
    supply_good = 1'b0;
    {freq_strap_code, boot_strap_code, slew_strap_code, addr_strap_code} = {f, b, s, a};
    repeat (2) @(negedge core_clk);
    supply_good = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask
  initial
  begin
    time t0;
    int n, ex;
    logic ack;
    logic [7:0] d;
    rst = 1'b1;
    {supply_good, slew_strap_code, system_power_input, light_load_in, power_state} = '0;
    {freq_strap_code, boot_strap_code, addr_strap_code, max_current_strap} = '0;
    system_power_sample = 8'h5a;
    phase_current_sense_input = 6'h30;
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    for (int k = 0; k < 16; k++)
    begin
      system_power_input = k[1];
      power_up(4'(k), 3'd0, k[0], 3'(k));
      check(switching_freq_khz, 16'(k < 9 ? 180 + 45 * k : 540 + 90 * (k - 8)));
      check({main_rail_address, second_rail_address}, {7'h0, k[0], 2'b00, k[1], ~(k[0] ^ k[1])});
      check(slew_select_out, k[0]);
      check(system_power_enabled, !k[1]);
      check(active_phase_mask, 6'h0f);
      check(rail_pwm_out, {VRSC_PWM_MID, VRSC_PWM_MID});
    end
    for (int b = 0; b < 7; b++)
    begin
      phase_current_sense_input = b == 6 ? 6'h3e : 6'h30;
      system_power_input = b[0];
      system_power_sample = 8'(29 * b + 3);
      max_current_strap = 8'(37 * b + 5);
      power_up(4'h0, b == 6 ? 3'd1 : 3'(b), b != 6, 3'(b));
      freq_strap_code = 4'hf;
      i_host.set_enable(1'b1);
      t0 = $time;
      repeat (2) @(negedge core_clk);
      check(gate_driver_enable_out, 1);
      check(rail_pwm_out, {VRSC_PWM_MID, VRSC_PWM_MID});
      if (b == 6)
      begin
        i_host.read(8'h00, 8'h21, ack, d);
        check(ack, 0);
      end
      wait_ready(1'b1, 20000);
      n = int'(($time - t0) / 5);
      ex = b == 0 ? 10 : (b == 6 ? 16000 : tgt[b] / 5 * 33);
      check(n >= ex * 95 / 100 && n <= ex * 105 / 100 + 8 && n <= 500000, 1);
      check(dac_mv_out, 16'(tgt[b == 6 ? 1 : b]));
      check(max_current_setting, max_current_strap);
      i_host.pulse(2'b01);
      check(rail_pwm_out, {VRSC_PWM_MID, VRSC_PWM_HIGH});
      i_host.pulse(2'b10);
      check(rail_pwm_out, {VRSC_PWM_HIGH, VRSC_PWM_HIGH});
      i_host.read({7'h0, b[0] && b != 6}, 8'h21, ack, d);
      check({ack, d}, {1'b1, max_current_strap});
      i_host.read(8'(sec[b % 4]), 8'h21, ack, d);
      check({ack, d}, {1'b1, max_current_strap});
      i_host.read(8'h09, 8'h21, ack, d);
      check(ack, 0);
      i_host.read(8'h0d, 8'h00, ack, d);
      check({ack, d}, {!b[0], b[0] ? 8'h00 : system_power_sample});
      for (int m = 0; m < 10; m++)
      begin
        power_state = 3'(m / 2);
        light_load_in = m[0];
        repeat (3) @(negedge core_clk);
        check(rail_mode_out, m < 2 ? (b == 6) : m < 4 ? 1 : m < 8 ? 3 - m[0] : 4);
      end
      i_host.set_enable(1'b0);
      repeat (150) @(negedge core_clk);
      check(rails_ready_out, 1);
      i_host.set_enable(1'b1);
      i_host.set_enable(1'b0);
      t0 = $time;
      wait_ready(1'b0, 400);
      check(($time - t0) <= 1500, 1);
      repeat (2) @(negedge core_clk);
      check({gate_driver_enable_out, rail_pwm_out}, {1'b0, VRSC_PWM_MID, VRSC_PWM_MID});
      check(switching_freq_khz, 180);
      // Reset during shutdown in the b == 3 pass: outputs must fall back to their idle values
      if (b == 3)
      begin
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        check({rails_ready_out, gate_driver_enable_out, rail_pwm_out}, {2'b00, VRSC_PWM_MID, VRSC_PWM_MID});
        check(dac_mv_out, 16'h0000);
        check(rail_mode_out, 16'(VRSC_MODE_STANDBY));
        rst = 1'b0;
      end
    end
    summarize();
  end
endmodule
bind vrsc_sequencer vrsc_sequencer_chk #(.NPH(NPH)) i_chk (.core_clk, .rst, .supply_good, .rail_enable_in,
  .power_state, .light_load_in, .rail_pulse_in, .bus_rd, .bus_addr, .bus_reg, .rails_ready_out,
  .gate_driver_enable_out, .rail_pwm_out, .dac_mv_out, .switching_freq_khz, .main_rail_address, .active_phase_mask,
  .system_power_enabled, .max_current_setting, .rail_mode_out, .bus_ack, .bus_rdata);
